//--- servo_monitor_display.sv
`timescale 1ns/1ns
module servo_monitor_display
   import monitor_pkg::*;
#(
   parameter longint unsigned HOLD_COUNT = HOLD_CYCLES,
   parameter longint unsigned LOAD_COUNT = LOAD_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   input  wire logic        mode_select_key,
   input  wire logic        key_up,
   input  wire logic        key_down,
   input  wire logic        key_enter,
   input  wire logic        key_shift,
   input  wire logic [1:0]  ctrl_mode,
   input  wire logic        encoder_17bit,
   input  wire logic [15:0] actual_speed,
   input  wire logic [15:0] speed_reference,
   input  wire logic [15:0] torque_ref_pct,
   input  wire logic [15:0] angle1_pulses,
   input  wire logic [15:0] angle2_deg,
   input  wire logic [15:0] ref_pulse_speed,
   input  wire logic [15:0] position_error,
   input  wire logic [15:0] load_rate_pct,
   input  wire logic [15:0] regen_rate_pct,
   input  wire logic [15:0] dynamic_braking_pct,
   input  wire logic [7:0]  input_terminals,
   input  wire logic [6:0]  output_conducting,
   input  wire logic        ref_pulse_fwd,
   input  wire logic        ref_pulse_rev,
   input  wire logic        fb_pulse_fwd,
   input  wire logic        fb_pulse_rev,
   output logic             monitor_active,
   output logic             show_data,
   output logic [3:0]       item_number,
   output logic [15:0]      display_value,
   output logic [1:0]       display_format,
   output logic             display_lower_half,
   output logic             display_valid,
   output logic [7:0]       segment_top,
   output logic [7:0]       segment_bottom,
   output logic [17:0]      fb_counts_per_rev
);

   // Keys and terminals come from pins: two stages before any use
   logic [12:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
   logic [12:0] pin_raw, pin_rise;

   assign pin_raw = {input_terminals, key_shift, key_enter, key_down,
                     key_up, mode_select_key};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_meta_reg <= 13'h0000;
         pin_sync_reg <= 13'h0000;
         pin_prev_reg <= 13'h0000;
      end else if (clk_en) begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   assign pin_rise = pin_sync_reg & ~pin_prev_reg;

   logic       up_held, down_held, shift_held;
   logic       mode_press, up_press, down_press, enter_press;
   logic [7:0] in_closed;

   assign mode_press  = pin_rise[0];
   assign up_held     = pin_sync_reg[1];
   assign down_held   = pin_sync_reg[2];
   assign shift_held  = pin_sync_reg[4];
   assign up_press    = pin_rise[1];
   assign down_press  = pin_rise[2];
   assign enter_press = pin_rise[3];
   assign in_closed   = pin_sync_reg[12:5];

   // Shift hold timer; fires once per hold so a long press is one confirm
   logic [31:0] hold_cnt_reg, hold_cnt_next;
   logic        hold_fire;

   always_comb begin
      hold_cnt_next = 32'h0000_0000;
      hold_fire     = 1'b0;
      if (shift_held) begin
         if (hold_cnt_reg == HOLD_COUNT[31:0] - 32'h0000_0001) begin
            hold_fire     = 1'b1;
            hold_cnt_next = HOLD_COUNT[31:0];
         end else if (hold_cnt_reg == HOLD_COUNT[31:0]) begin
            hold_cnt_next = hold_cnt_reg;
         end else begin
            hold_cnt_next = hold_cnt_reg + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_cnt_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         hold_cnt_reg <= hold_cnt_next;
      end
   end

   // Panel sequencer
   panel_state_t state_reg, state_next;
   logic [3:0]   item_reg, item_next;
   logic         lower_reg, lower_next;
   logic         confirm, both_keys, counter_item;
   logic         clear_ref, clear_fb;

   assign confirm      = enter_press || hold_fire;
   assign both_keys    = up_held && down_held && (up_press || down_press);
   assign counter_item = (item_reg == ITEM_REF_PULSE_CNT) ||
                         (item_reg == ITEM_FB_PULSE_CNT);

   always_comb begin
      state_next = state_reg;
      item_next  = item_reg;
      lower_next = lower_reg;
      clear_ref  = 1'b0;
      clear_fb   = 1'b0;
      case (state_reg)
         ST_OFF: begin
            if (mode_press) begin
               state_next = ST_ITEM;
            end
         end
         ST_ITEM: begin
            if (mode_press) begin
               state_next = ST_OFF;
            end else if (confirm) begin
               state_next = ST_DATA;
               lower_next = 1'b0;
            end else if (up_press && !down_held) begin
               item_next = (item_reg == ITEM_LAST) ? ITEM_RESET
                                                   : item_reg + 4'h1;
            end else if (down_press && !up_held) begin
               item_next = (item_reg == ITEM_RESET) ? ITEM_LAST
                                                    : item_reg - 4'h1;
            end
         end
         ST_DATA: begin
            if (mode_press) begin
               state_next = ST_OFF;
            end else if (confirm) begin
               state_next = ST_ITEM;
            end else if (counter_item && lower_reg && both_keys) begin
               clear_ref = (item_reg == ITEM_REF_PULSE_CNT);
               clear_fb  = (item_reg == ITEM_FB_PULSE_CNT);
            end else if (counter_item && (up_press || down_press)) begin
               lower_next = 1'b1;
            end
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_OFF;
         item_reg  <= ITEM_RESET;
         lower_reg <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         item_reg  <= item_next;
         lower_reg <= lower_next;
      end
   end

   logic [31:0] ref_count, fb_count;

   pulse_counter u_ref_counter (
      .clk        (clk),
      .rst        (rst),
      .clk_en     (clk_en),
      .count_up   (ref_pulse_fwd),
      .count_down (ref_pulse_rev),
      .clear      (clear_ref),
      .count      (ref_count)
   );

   // Feedback strobes arrive at four per encoder line (quadrature edges)
   pulse_counter u_fb_counter (
      .clk        (clk),
      .rst        (rst),
      .clk_en     (clk_en),
      .count_up   (fb_pulse_fwd),
      .count_down (fb_pulse_rev),
      .clear      (clear_fb),
      .count      (fb_count)
   );

   // Load figures are taken once per 10 s window so the panel reads steady
   logic [31:0] load_cnt_reg, load_cnt_next;
   logic [47:0] load_hold_reg, load_hold_next;

   always_comb begin
      load_cnt_next  = load_cnt_reg + 32'h0000_0001;
      load_hold_next = load_hold_reg;
      if (load_cnt_reg == LOAD_COUNT[31:0] - 32'h0000_0001) begin
         load_cnt_next  = 32'h0000_0000;
         load_hold_next = {dynamic_braking_pct, regen_rate_pct,
                           load_rate_pct};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         load_cnt_reg  <= 32'h0000_0000;
         load_hold_reg <= 48'h0000_0000_0000;
      end else if (clk_en) begin
         load_cnt_reg  <= load_cnt_next;
         load_hold_reg <= load_hold_next;
      end
   end

   // Display path, refreshed every cycle that clk_en is high, whatever the motor is doing
   logic [15:0] value_next, value_reg;
   logic [1:0]  format_next, format_reg;
   logic        valid_next, valid_reg;
   logic [7:0]  top_next, top_reg;
   logic [7:0]  bottom_next, bottom_reg;
   logic [31:0] count_sel;
   logic        pos_mode;

   assign pos_mode  = (ctrl_mode == CTRL_POSITION);
   assign count_sel = (item_reg == ITEM_REF_PULSE_CNT) ? ref_count
                                                       : fb_count;

   always_comb begin
      value_next  = VALUE_RESET;
      format_next = FMT_DECIMAL;
      valid_next  = 1'b1;
      top_next    = 8'h00;
      bottom_next = 8'h00;
      case (item_reg)
         ITEM_ACTUAL_SPEED:  value_next = actual_speed;
         ITEM_SPEED_REF: begin
            value_next = speed_reference;
            valid_next = (ctrl_mode == CTRL_SPEED);
         end
         ITEM_TORQUE_REF:    value_next = torque_ref_pct;
         ITEM_ANGLE1:        value_next = angle1_pulses;
         ITEM_ANGLE2:        value_next = angle2_deg;
         ITEM_INPUT_MON: begin
            format_next = FMT_SEGMENTS;
            top_next    = ~in_closed;
            bottom_next = in_closed;
         end
         ITEM_OUTPUT_MON: begin
            // Conducting output pulls its line low, which lights bottom
            format_next = FMT_SEGMENTS;
            top_next    = {1'b0, ~output_conducting};
            bottom_next = {1'b0, output_conducting};
         end
         ITEM_REF_PULSE_SPD: begin
            value_next = ref_pulse_speed;
            valid_next = pos_mode;
         end
         ITEM_POS_ERROR: begin
            value_next = position_error;
            valid_next = pos_mode;
         end
         ITEM_LOAD_RATE:     value_next = load_hold_reg[15:0];
         ITEM_REGEN_RATE:    value_next = load_hold_reg[31:16];
         ITEM_BRAKING_POWER: value_next = load_hold_reg[47:32];
         ITEM_REF_PULSE_CNT, ITEM_FB_PULSE_CNT: begin
            format_next = FMT_HEX;
            value_next  = lower_reg ? count_sel[15:0]
                                    : count_sel[31:16];
            valid_next  = (item_reg == ITEM_FB_PULSE_CNT) || pos_mode;
         end
         default: valid_next = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         value_reg  <= VALUE_RESET;
         format_reg <= FMT_DECIMAL;
         valid_reg  <= 1'b0;
         top_reg    <= 8'h00;
         bottom_reg <= 8'h00;
      end else if (clk_en) begin
         value_reg  <= value_next;
         format_reg <= format_next;
         valid_reg  <= valid_next;
         top_reg    <= top_next;
         bottom_reg <= bottom_next;
      end
   end

   assign monitor_active     = (state_reg != ST_OFF);
   assign show_data          = (state_reg == ST_DATA);
   assign item_number        = item_reg;
   assign display_value      = value_reg;
   assign display_format     = format_reg;
   assign display_lower_half = lower_reg;
   assign display_valid      = valid_reg;
   assign segment_top        = top_reg;
   assign segment_bottom     = bottom_reg;
   assign fb_counts_per_rev  = encoder_17bit ? FB_COUNTS_17BIT_ENC
                                             : FB_COUNTS_16BIT_ENC;

endmodule : servo_monitor_display

//--- monitor_pkg.sv
`timescale 1ns/1ns
package monitor_pkg;

   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned HOLD_TIME_MS  = 1000;
   localparam int unsigned LOAD_CYCLE_S  = 10;
   localparam longint unsigned HOLD_CYCLES =
      (64'd1000000 * HOLD_TIME_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam longint unsigned LOAD_CYCLES =
      (64'd1000000000 * LOAD_CYCLE_S) / CLK_PERIOD_NS;

   localparam logic [3:0]  ITEM_ACTUAL_SPEED   = 4'h0;
   localparam logic [3:0]  ITEM_SPEED_REF      = 4'h1;
   localparam logic [3:0]  ITEM_TORQUE_REF     = 4'h2;
   localparam logic [3:0]  ITEM_ANGLE1         = 4'h3;
   localparam logic [3:0]  ITEM_ANGLE2         = 4'h4;
   localparam logic [3:0]  ITEM_INPUT_MON      = 4'h5;
   localparam logic [3:0]  ITEM_OUTPUT_MON     = 4'h6;
   localparam logic [3:0]  ITEM_REF_PULSE_SPD  = 4'h7;
   localparam logic [3:0]  ITEM_POS_ERROR      = 4'h8;
   localparam logic [3:0]  ITEM_LOAD_RATE      = 4'h9;
   localparam logic [3:0]  ITEM_REGEN_RATE     = 4'hA;
   localparam logic [3:0]  ITEM_BRAKING_POWER  = 4'hB;
   localparam logic [3:0]  ITEM_REF_PULSE_CNT  = 4'hC;
   localparam logic [3:0]  ITEM_FB_PULSE_CNT   = 4'hD;
   localparam logic [3:0]  ITEM_LAST           = 4'hD;
   localparam logic [3:0]  ITEM_RESET          = 4'h0;

   localparam logic [1:0]  CTRL_SPEED          = 2'h0;
   localparam logic [1:0]  CTRL_POSITION       = 2'h1;
   localparam logic [1:0]  CTRL_TORQUE         = 2'h2;

   localparam logic [1:0]  FMT_DECIMAL         = 2'h0;
   localparam logic [1:0]  FMT_HEX             = 2'h1;
   localparam logic [1:0]  FMT_SEGMENTS        = 2'h2;

   localparam logic [17:0] FB_COUNTS_16BIT_ENC = 18'h10000;
   localparam logic [17:0] FB_COUNTS_17BIT_ENC = 18'h1FFFF;

   localparam logic [31:0] COUNT_RESET         = 32'h0000_0000;
   localparam logic [15:0] VALUE_RESET         = 16'h0000;

   typedef enum logic [1:0] {
      ST_OFF  = 2'b00,
      ST_ITEM = 2'b01,
      ST_DATA = 2'b11
   } panel_state_t;

endpackage : monitor_pkg

module pulse_counter
   import monitor_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   input  wire logic        count_up,
   input  wire logic        count_down,
   input  wire logic        clear,
   output logic [31:0]      count
);
   logic [31:0] count_reg;
   logic [31:0] count_next;

   always_comb begin
      count_next = count_reg;
      if (clear) begin
         // Whole word cleared at once so halves never disagree
         count_next = COUNT_RESET;
      end else if (count_up && !count_down) begin
         count_next = count_reg + 32'h0000_0001;
      end else if (count_down && !count_up) begin
         count_next = count_reg - 32'h0000_0001;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_reg <= COUNT_RESET;
      end else if (clk_en) begin
         count_reg <= count_next;
      end
   end

   assign count = count_reg;

endmodule : pulse_counter

//--- servo_monitor_display_properties.sv
`timescale 1ns/1ns
module monitor_checker
   import monitor_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        encoder_17bit,
   input wire logic [1:0]  ctrl_mode,
   input wire logic [7:0]  input_terminals,
   input wire logic [6:0]  output_conducting,
   input wire logic        fb_pulse_fwd,
   input wire logic        fb_pulse_rev,
   input wire logic        monitor_active,
   input wire logic        show_data,
   input wire logic [3:0]  item_number,
   input wire logic [15:0] display_value,
   input wire logic [1:0]  display_format,
   input wire logic        display_lower_half,
   input wire logic        display_valid,
   input wire logic [7:0]  segment_top,
   input wire logic [7:0]  segment_bottom,
   input wire logic [17:0] fb_counts_per_rev
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);

   a_per_rev_sel: assert property (
      fb_counts_per_rev == (encoder_17bit ? FB_COUNTS_17BIT_ENC
                                          : FB_COUNTS_16BIT_ENC))
      else $error("counts per revolution wrong");
   a_data_in_mon: assert property (
      $rose(show_data) |-> $past(monitor_active))
      else $error("data view entered from outside monitor mode");
   a_item_range: assert property (
      item_number <= ITEM_LAST)
      else $error("item number out of range");
   // Five cycles cover the two sync stages and the display register
   a_input_segs: assert property (
      ($stable(input_terminals) && show_data
       && item_number == ITEM_INPUT_MON) [*5]
      |-> segment_bottom == input_terminals
          && segment_top == ~input_terminals)
      else $error("input segments wrong");
   a_output_segs: assert property (
      ($stable(output_conducting) && show_data
       && item_number == ITEM_OUTPUT_MON) [*3]
      |-> segment_bottom[6:0] == output_conducting
          && segment_top[6:0] == ~output_conducting)
      else $error("output segments wrong");
   a_upper_first: assert property (
      $rose(show_data) && item_number >= ITEM_REF_PULSE_CNT
      |-> !display_lower_half)
      else $error("counter view did not start on upper half");
   a_hex_counter: assert property (
      show_data && $past(show_data)
      && item_number == ITEM_FB_PULSE_CNT |-> display_format == FMT_HEX)
      else $error("feedback counter not hexadecimal");
   a_pos_err_valid: assert property (
      show_data && $past(show_data) && item_number == ITEM_POS_ERROR
      && $stable(ctrl_mode) && ctrl_mode != CTRL_POSITION
      |-> !display_valid)
      else $error("position error valid outside position mode");
   // Quiet cycles either side let the check hold for a pulse-to-display delay of up to two cycles
   a_fwd_step: assert property (
      (!fb_pulse_fwd && !fb_pulse_rev && display_lower_half) [*2]
      ##1 (fb_pulse_fwd && !fb_pulse_rev && show_data
           && display_lower_half && item_number == ITEM_FB_PULSE_CNT)
      ##1 (!fb_pulse_fwd && !fb_pulse_rev && display_lower_half) [*3]
      |-> display_value == $past(display_value, 4) + 16'h0001)
      else $error("forward pulse did not add one");
endmodule : monitor_checker

//--- keypad_model.sv
`timescale 1ns/1ns
module keypad_model (
   input  wire logic clk,
   output logic      mode_select_key,
   output logic      key_up,
   output logic      key_down,
   output logic      key_enter,
   output logic      key_shift
);
   initial begin
      {mode_select_key, key_up, key_down, key_enter, key_shift} = 5'h00;
   end

   // Keys: mode, up, down, enter, shift; a long hold is a slow operator
   task automatic press(input logic [4:0] keys, input int hold);
      @(posedge clk);
      #1;
      {mode_select_key, key_up, key_down,
       key_enter, key_shift} = keys;
      repeat (hold) @(posedge clk);
      #1;
      {mode_select_key, key_up, key_down, key_enter, key_shift} = 5'h00;
      // Release gap lets the edge detector rearm before the next press
      repeat (8) @(posedge clk);
      #1;
   endtask : press
endmodule : keypad_model

//--- test_servo_monitor_display.sv
`timescale 1ns/1ns
module test_servo_monitor_display
   import monitor_pkg::*;
;
   localparam int HOLD = 8;
   localparam int LOADN = 16;
   localparam logic [4:0] K_MODE = 5'h10;
   localparam logic [4:0] K_UP = 5'h08;
   localparam logic [4:0] K_DOWN = 5'h04;
   localparam logic [4:0] K_ENTER = 5'h02;
   localparam logic [4:0] K_SHIFT = 5'h01;
   logic        clk, rst, clk_en, encoder_17bit;
   logic        mode_select_key, key_up, key_down, key_enter, key_shift;
   logic [1:0]  ctrl_mode, display_format;
   logic [15:0] src [12];
   logic [7:0]  input_terminals, segment_top, segment_bottom;
   logic [6:0]  output_conducting;
   logic        ref_pulse_fwd, ref_pulse_rev, fb_pulse_fwd, fb_pulse_rev;
   logic        monitor_active, show_data, display_lower_half, display_valid;
   logic [3:0]  item_number;
   logic [15:0] display_value;
   logic [17:0] fb_counts_per_rev;
   int          failures, cmp_count;

   servo_monitor_display #(.HOLD_COUNT(HOLD), .LOAD_COUNT(LOADN))
      i_servo_monitor_display (
      .clk, .rst, .clk_en, .mode_select_key, .key_up, .key_down,
      .key_enter, .key_shift, .ctrl_mode, .encoder_17bit,
      .actual_speed(src[0]), .speed_reference(src[1]),
      .torque_ref_pct(src[2]), .angle1_pulses(src[3]),
      .angle2_deg(src[4]), .ref_pulse_speed(src[7]),
      .position_error(src[8]), .load_rate_pct(src[9]),
      .regen_rate_pct(src[10]), .dynamic_braking_pct(src[11]),
      .input_terminals, .output_conducting, .ref_pulse_fwd,
      .ref_pulse_rev, .fb_pulse_fwd, .fb_pulse_rev, .monitor_active,
      .show_data, .item_number, .display_value, .display_format,
      .display_lower_half, .display_valid, .segment_top,
      .segment_bottom, .fb_counts_per_rev);
   keypad_model i_keypad_model (.clk, .mode_select_key, .key_up,
      .key_down, .key_enter, .key_shift);

   always #5 clk = ~clk;

   task automatic cmp(input string what, input logic [17:0] exp,
                      input logic [17:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic key(input logic [4:0] k);
      i_keypad_model.press(k, 3);
   endtask : key

   task automatic goto_item(input logic [3:0] n);
      for (int i = 0; i < 16 && item_number !== n; i++)
         key(K_UP);
      cmp("item", n, item_number);
   endtask : goto_item

   task automatic pulse(input bit fb, input bit fwd, input int n);
      repeat (n) begin
         if (fb)
            {fb_pulse_fwd, fb_pulse_rev} = {fwd, !fwd};
         else
            {ref_pulse_fwd, ref_pulse_rev} = {fwd, !fwd};
         tick(1);
      end
      {ref_pulse_fwd, ref_pulse_rev, fb_pulse_fwd, fb_pulse_rev} = 4'h0;
      tick(3);
   endtask : pulse

   function automatic logic exp_valid(input logic [3:0] it,
                                      input logic [1:0] m);
      if (it == ITEM_SPEED_REF)
         return m == CTRL_SPEED;
      if (it == ITEM_REF_PULSE_SPD || it == ITEM_POS_ERROR)
         return m == CTRL_POSITION;
      return 1'b1;
   endfunction : exp_valid

   task automatic t_reset;
      cmp("active", 0, monitor_active);
      cmp("item", ITEM_RESET, item_number);
      cmp("rev16", FB_COUNTS_16BIT_ENC, fb_counts_per_rev);
      encoder_17bit = 1'b1;
      tick(1);
      cmp("rev17", FB_COUNTS_17BIT_ENC, fb_counts_per_rev);
      $display("test reset done");
   endtask : t_reset

   task automatic t_nav;
      key(K_UP);
      cmp("off item", ITEM_RESET, item_number);
      key(K_MODE);
      cmp("active", 1, monitor_active);
      key(K_UP);
      cmp("up", 4'h1, item_number);
      key(K_DOWN);
      key(K_DOWN);
      cmp("wrap", ITEM_LAST, item_number);
      key(K_UP);
      key(K_ENTER);
      cmp("data", 1, show_data);
      src[0] = 16'h05DC;
      tick(4);
      cmp("live", 16'h05DC, display_value);
      key(K_ENTER);
      cmp("back", 0, show_data);
      $display("test navigation done");
   endtask : t_nav

   task automatic t_items(input logic [1:0] mode);
      logic ok;
      ctrl_mode = mode;
      for (int k = 0; k < 12; k++) begin
         if (k == 5 || k == 6)
            continue;
         goto_item(4'(k));
         key(K_ENTER);
         tick(2 * LOADN);
         ok = exp_valid(4'(k), mode);
         if (k >= 9)
            cmp("pct", src[k], display_value);
         else if (ok)
            cmp("value", src[k], display_value);
         cmp("format", FMT_DECIMAL, display_format);
         cmp("valid", ok, display_valid);
         key(K_ENTER);
      end
      $display("test items done");
   endtask : t_items

   task automatic t_terms;
      goto_item(ITEM_INPUT_MON);
      key(K_ENTER);
      input_terminals = 8'hA5;
      tick(6);
      cmp("in top", 8'h5A, segment_top);
      cmp("in bottom", 8'hA5, segment_bottom);
      key(K_ENTER);
      key(K_UP);
      key(K_ENTER);
      output_conducting = 7'h4C;
      tick(4);
      cmp("out top", 7'h33, segment_top[6:0]);
      cmp("out bottom", 7'h4C, segment_bottom[6:0]);
      cmp("fmt", FMT_SEGMENTS, display_format);
      key(K_ENTER);
      $display("test terminals done");
   endtask : t_terms

   task automatic t_count;
      ctrl_mode = CTRL_POSITION;
      goto_item(ITEM_FB_PULSE_CNT);
      key(K_ENTER);
      cmp("upper", 0, display_value);
      cmp("half", 0, display_lower_half);
      cmp("hex", FMT_HEX, display_format);
      pulse(1, 0, 1);
      cmp("upper wrap", 16'hFFFF, display_value);
      key(K_UP);
      cmp("half", 1, display_lower_half);
      pulse(1, 1, 1);
      cmp("wrap up", 16'h0000, display_value);
      pulse(1, 1, 3);
      cmp("lower", 16'h0003, display_value);
      // Pulses while the enable is low must leave the count untouched
      clk_en = 1'b0;
      pulse(1, 1, 2);
      clk_en = 1'b1;
      tick(2);
      cmp("frozen", 16'h0003, display_value);
      pulse(1, 0, 4);
      key(K_UP | K_DOWN);
      cmp("clear", 16'h0000, display_value);
      key(K_ENTER);
      key(K_ENTER);
      cmp("upper clear", 16'h0000, display_value);
      key(K_ENTER);
      pulse(0, 1, 5);
      goto_item(ITEM_REF_PULSE_CNT);
      key(K_ENTER);
      key(K_DOWN);
      cmp("ref lower", 16'h0005, display_value);
      key(K_ENTER);
      $display("test counters done");
   endtask : t_count

   task automatic t_shift;
      goto_item(ITEM_ACTUAL_SPEED);
      i_keypad_model.press(K_SHIFT, HOLD - 3);
      cmp("short hold", 0, show_data);
      i_keypad_model.press(K_SHIFT, 4 * HOLD);
      cmp("long hold", 1, show_data);
      i_keypad_model.press(K_SHIFT, HOLD + 4);
      cmp("hold back", 0, show_data);
      $display("test shift hold done");
   endtask : t_shift

   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      clk_en = 1'b1;
      encoder_17bit = 1'b0;
      ctrl_mode = CTRL_SPEED;
      input_terminals = 8'h00;
      output_conducting = 7'h00;
      {ref_pulse_fwd, ref_pulse_rev, fb_pulse_fwd, fb_pulse_rev} = 4'h0;
      foreach (src[i])
         src[i] = 16'h1234 + 16'(i) * 16'h0101;
      tick(8);
      rst = 1'b0;
      t_reset();
      t_nav();
      t_items(CTRL_SPEED);
      t_items(CTRL_POSITION);
      t_items(CTRL_TORQUE);
      t_terms();
      t_count();
      t_shift();
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      complete_run();
   end
endmodule : test_servo_monitor_display

bind servo_monitor_display monitor_checker i_monitor_checker (
   .clk, .rst, .encoder_17bit, .ctrl_mode, .input_terminals,
   .output_conducting, .fb_pulse_fwd, .fb_pulse_rev, .monitor_active,
   .show_data, .item_number, .display_value, .display_format,
   .display_lower_half, .display_valid, .segment_top, .segment_bottom,
   .fb_counts_per_rev);
